// *** src/acs_channel_config.sv ***
// Channel 0 configuration register with its register port and channel sequencing
`timescale 1ns/1ps
module acs_channel_config
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port behind the serial interface
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [15:0] regWrData,
  input wire logic regRead,
  output logic [15:0] regRdData,
  output logic regRdValid,
  // Enables of channels 1 to 3, from their own registers
  input wire logic [ACS_NUM_CH-1:1] otherEnable,
  // Conversion progress from the modulator and filter
  input wire logic convDone,
  // Channel 0 fields as used by the converter
  output logic channel_enable_bit,
  output logic [ACS_SETUP_W-1:0] setup_choice_field,
  output logic [ACS_SEL_W-1:0] positive_input_selector,
  output logic [ACS_SEL_W-1:0] negative_input_selector,
  // Sequencer view
  output logic [1:0] activeChannel,
  output logic sequencing,
  output logic chanZeroActive,
  output logic [ACS_SETUP_W-1:0] convSetup
);
  // Stored register and its next value
  logic [15:0] channel_zero_config;
  logic [15:0] next_config;
  logic [15:0] readWord;
  logic [1:0] seqChan;
  logic seqOn;
  logic hitCfg;
  logic writeHit;

  // Register layout, most significant bit first
  //   15     channel enable
  //   14     reserved, reads zero
  //   13:12  setup choice
  //   11:10  reserved, reads zero
  //   9:5    positive input route
  //   4:0    negative input route

  // Field extraction is shared by the reset values and the live register
  function automatic logic fieldEnable(input logic [15:0] word);
    logic enableFlag;
    enableFlag = word[ACS_EN_BIT];
    return enableFlag;
  endfunction

  function automatic logic [ACS_SETUP_W-1:0] fieldSetup(input logic [15:0] word);
    logic [ACS_SETUP_W-1:0] setupCode;
    setupCode = word[ACS_SETUP_LSB +: ACS_SETUP_W];
    return setupCode;
  endfunction

  function automatic logic [ACS_SEL_W-1:0] fieldPositive(input logic [15:0] word);
    logic [ACS_SEL_W-1:0] routeCode;
    routeCode = word[ACS_POS_LSB +: ACS_SEL_W];
    return routeCode;
  endfunction

  function automatic logic [ACS_SEL_W-1:0] fieldNegative(input logic [15:0] word);
    logic [ACS_SEL_W-1:0] routeCode;
    routeCode = word[ACS_NEG_LSB +: ACS_SEL_W];
    return routeCode;
  endfunction

  // True while the sequencer sits on channel 0
  function automatic logic onChannelZero(input logic [1:0] chan);
    logic isZero;
    isZero = (chan == ACS_FIRST_CHAN);
    return isZero;
  endfunction

  // Only the one mapped address is decoded; everything else is unmapped
  assign hitCfg = (regAddr == ACS_CFG_ADDR);
  assign writeHit = regWrite && hitCfg;

  // Reserved bits are dropped here, so they can never read back as one
  always_comb begin
    next_config = channel_zero_config;
    if (writeHit) begin
      next_config = regWrData & ACS_CFG_WMASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      channel_zero_config <= ACS_CFG_RESET;
    end else begin
      channel_zero_config <= next_config;
    end
  end

  // A read in the same cycle as a write sees the old contents
  always_comb begin
    readWord = ACS_UNMAPPED_DATA;
    if (hitCfg) begin
      readWord = channel_zero_config;
    end
  end

  // Valid is a one-cycle pulse for every read, mapped or not
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
    end
  end

  // Read data holds until the next read so a slow host can pick it up late
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regRdData <= ACS_UNMAPPED_DATA;
    end else if (regRead) begin
      regRdData <= readWord;
    end
  end

  // Field outputs trail the register by one cycle; this keeps every output on a flop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      channel_enable_bit <= fieldEnable(ACS_CFG_RESET);
    end else begin
      channel_enable_bit <= fieldEnable(channel_zero_config);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      setup_choice_field <= fieldSetup(ACS_CFG_RESET);
    end else begin
      setup_choice_field <= fieldSetup(channel_zero_config);
    end
  end

  // Codes are passed as written; unlisted codes are the host's problem
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      positive_input_selector <= fieldPositive(ACS_CFG_RESET);
    end else begin
      positive_input_selector <= fieldPositive(channel_zero_config);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      negative_input_selector <= fieldNegative(ACS_CFG_RESET);
    end else begin
      negative_input_selector <= fieldNegative(channel_zero_config);
    end
  end

  // Enable comes from the register, not the field output, to save a cycle
  // Widening the enables by position keeps channel n on bit n
  acs_sequencer u_seq (
    .clk_sys(clk_sys),
    .rst(rst),
    .chanEnable({otherEnable, fieldEnable(channel_zero_config)}),
    .convDone(convDone),
    .activeChan(seqChan),
    .seqActive(seqOn)
  );

  // Output copy of the sequencer position
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      activeChannel <= ACS_FIRST_CHAN;
    end else begin
      activeChannel <= seqChan;
    end
  end

  // Any enabled channel keeps the sequencer running
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sequencing <= 1'b0;
    end else begin
      sequencing <= seqOn;
    end
  end

  // Channel 0 only counts as converting while it is still enabled
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chanZeroActive <= 1'b0;
    end else begin
      chanZeroActive <= seqOn && onChannelZero(seqChan) && fieldEnable(channel_zero_config);
    end
  end

  // Setup choice is loaded from channel 0's register only while the sequencer sits on channel 0; otherwise it holds
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      convSetup <= fieldSetup(ACS_CFG_RESET);
    end else begin
      if (onChannelZero(seqChan)) begin
        convSetup <= fieldSetup(channel_zero_config);
      end
    end
  end
endmodule

// *** src/acs_pkg.sv ***
// Constants for the channel 0 configuration register and the channel sequencer
package acs_pkg;
  localparam logic [7:0] ACS_CFG_ADDR = 8'h10;
  localparam logic [15:0] ACS_CFG_RESET = 16'h8001;
  localparam logic [15:0] ACS_CFG_WMASK = 16'hB3FF;
  localparam int ACS_EN_BIT = 15;
  localparam int ACS_RSV_HI_BIT = 14;
  localparam int ACS_SETUP_LSB = 12;
  localparam int ACS_SETUP_W = 2;
  localparam int ACS_POS_LSB = 5;
  localparam int ACS_NEG_LSB = 0;
  localparam int ACS_SEL_W = 5;
  localparam int ACS_NUM_CH = 4;
  localparam logic [15:0] ACS_UNMAPPED_DATA = 16'h0000;
  localparam logic [1:0] ACS_FIRST_CHAN = 2'h0;
endpackage

// *** src/acs_sequencer.sv ***
// Round-robin stepping through the enabled channels
`timescale 1ns/1ps
module acs_sequencer
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Channel enables and conversion progress
  input wire logic [ACS_NUM_CH-1:0] chanEnable,
  input wire logic convDone,
  // Sequencer state
  output logic [1:0] activeChan,
  output logic seqActive
);
  // Next enabled channel after the given one, wrapping round; itself if it is the only one
  function automatic logic [1:0] nextEnabled(input logic [1:0] cur, input logic [ACS_NUM_CH-1:0] en);
    logic [1:0] pick;
    logic [1:0] cand;
    pick = cur;
    for (int i = ACS_NUM_CH - 1; i >= 1; i--) begin
      cand = 2'(cur + 2'(i));
      if (en[cand]) begin
        pick = cand;
      end
    end
    return pick;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      activeChan <= ACS_FIRST_CHAN;
    end else if (!chanEnable[activeChan] && (chanEnable != '0)) begin
      // Current channel was switched off: move on at once rather than waste a conversion
      activeChan <= nextEnabled(activeChan, chanEnable);
    end else if (convDone) begin
      activeChan <= nextEnabled(activeChan, chanEnable);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seqActive <= 1'b0;
    end else begin
      seqActive <= (chanEnable != '0);
    end
  end
endmodule

// *** verification/acs_channel_config_asserts.sv ***
// Checks on the register port and the channel enable field output
`timescale 1ns/1ps
module acs_channel_config_asserts (
  // Watched ports
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [15:0] regWrData,
  input wire logic regRead,
  input wire logic [15:0] regRdData,
  input wire logic regRdValid,
  input wire logic channel_enable_bit
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_unmapped_read: assert property (regRead && regAddr != 8'h10 |=> regRdData == 16'h0) else $error("unmapped");
  a_read_hold: assert property (!regRead |=> $stable(regRdData)) else $error("moved");
  a_reserved_zero: assert property ((regRdData & 16'h4C00) == 16'h0) else $error("reserved");
  a_write_readback: assert property (regWrite && regAddr == 8'h10 ##1 !regWrite ##1 regRead && regAddr == 8'h10
    |=> regRdData == ($past(regWrData, 3) & 16'hB3FF)) else $error("readback");
  a_read_valid: assert property (regRead |=> regRdValid) else $error("no valid");
  a_valid_pulse: assert property (!regRead |=> !regRdValid) else $error("extra valid");
  a_enable_follow: assert property (regWrite && regAddr == 8'h10 |=> ##1
    channel_enable_bit == $past(regWrData[15], 2)) else $error("enable field");
endmodule

// *** verification/tb_top.sv ***
// Register bench
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'h0, rst = 1'h1, regWrite = 1'h0, regRead = 1'h0, convDone = 1'h0;
  logic regRdValid, channel_enable_bit, sequencing, chanZeroActive;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000, regRdData, d;
  logic [2:0] otherEnable = 3'h0;
  logic [1:0] setup_choice_field, activeChannel, convSetup;
  logic [4:0] positive_input_selector, negative_input_selector;
  int err_count = 0, tests_run = 0;
  acs_channel_config i_acs_channel_config(.*);
  initial forever #12.5 clk_sys = ~clk_sys;
  function automatic logic [15:0] masked(logic [15:0] v);
    return v & 16'hB3FF;
  endfunction
  // Only listed selector codes, supply-span codes left out since buffer state is unknown here
  function automatic logic [4:0] legalSel(int unsigned r);
    int unsigned k;
    k = r % 9;
    if (k < 5) return 5'(k);
    if (k < 7) return 5'(k + 12);
    return 5'(k + 14);
  endfunction
  function automatic logic [15:0] expFields(logic [15:0] v);
    return {3'h0, v[15], v[13:12], v[9:5], v[4:0]};
  endfunction
  function automatic logic [15:0] fieldsNow();
    return {3'h0, channel_enable_bit, setup_choice_field, positive_input_selector, negative_input_selector};
  endfunction
  task automatic chk(logic [15:0] got, exp);
    tests_run++;
    if (got === exp) return;
    err_count++;
    $display("BAD %0t got %h exp %h", $time, got, exp);
  endtask
  // A missing valid pulse turns the read data into a sure mismatch
  task automatic acc(logic w, logic [7:0] a, logic [15:0] v);
    @(posedge clk_sys) #1 regAddr = a;
    regWrData = v;
    {regWrite, regRead} = {w, !w};
    @(posedge clk_sys) #1 {regWrite, regRead} = 2'h0;
    if (!w) chk(regRdValid ? regRdData : ~v, v);
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20000 err_count++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(43));
    #88.5 rst = 1'h0;
    acc(1'h0, 8'h10, 16'h8001);
    chk(fieldsNow(), expFields(16'h8001));
    for (int i = 0; i < 20; i++) begin
      d = i == 0 ? 16'hB2D6 : {1'($urandom), 1'h0, 2'($urandom), 2'h0, legalSel($urandom), legalSel($urandom)};
      acc(1'h1, 8'h10, d);
      acc(1'h0, 8'h10, masked(d));
      chk(fieldsNow(), expFields(d));
    end
    acc(1'h1, 8'h11, 16'hFFFF);
    acc(1'h0, 8'h11, 16'h0000);
    acc(1'h0, 8'h10, masked(d));
    otherEnable = 3'h4;
    acc(1'h1, 8'h10, 16'h0000);
    acc(1'h1, 8'h10, 16'hA000);
    #50 convDone = 1'h1;
    #25 convDone = 1'h0;
    #100 chk({10'h000, activeChannel, convSetup, chanZeroActive, sequencing}, 16'h000B);
    tally_and_finish;
  end
endmodule
bind acs_channel_config acs_channel_config_asserts i_acs_channel_config_asserts(.*);
